// ==== src/mem_space_decode.sv ====
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// - Direct addresses 00-7F reach general registers and 80-FF reach special function registers.
// - A second 128-byte bank sits at 80-FF and is reached only by indirect addressing.
// - Indirect accesses take their 8-bit index from index register zero or one and also reach 0-127.
// - Stack pushes and pops are indirect, so a stack above 7F lands in the upper bank.
// - The special function range is sparse, holding core registers and added port registers.
// - Program memory is read-only and the fetch strobe fires only for fetches and code reads.
// - Data memory is its own 64 KB space, read and written by the data strobes.
// - With external code select low, internal RAM is read on a fetch strobe or a data read strobe.
// - Accesses to the internal 8 KB hold external read, write, chip select and output enable inactive, except code requests with select high.
// - Fetch and data read strobes leave on separate pins, keeping external spaces distinct.
// - With external code select high, internal RAM answers data reads only and fetches go external from 0000.
// - With external code select high, the core leaves power-up running rather than held in reset.
// - Each instruction cycle lasts 4 clocks and paces memory accesses.
module mem_space_decode (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // pins
   input wire logic external_code_select,
   input wire logic [7:0] port_e_pins,
   output logic [7:0] port_d_out,
   // core side: register memory
   input wire memdec_pkg::reg_req_t reg_req,
   output logic [7:0] reg_rdata,
   // core side: code and data memory
   input wire memdec_pkg::mem_req_t mem_req,
   output logic [7:0] mem_rdata,
   // pacing and run state
   output logic cycle_strobe,
   output logic core_hold,
   // internal shared RAM
   output logic int_ram_rd,
   output logic int_ram_wr,
   output logic [12:0] int_ram_addr,
   output logic [7:0] int_ram_wdata,
   input wire logic [7:0] int_ram_rdata,
   // external memory bus
   output memdec_pkg::ext_bus_t ext_bus,
   input wire logic [7:0] ext_rdata
);

   typedef struct packed {
      logic [1:0] phase;
      logic ecs_meta;
      logic ecs_sync;
      logic held;
      logic [7:0] index0;
      logic [7:0] index1;
      logic [7:0] reg_rdata;
      logic [7:0] mem_rdata;
      memdec_pkg::ext_bus_t bus;
   } dec_state_t;

   dec_state_t state_reg;
   dec_state_t state_next;

   logic [7:0] lower_ram [memdec_pkg::REG_BYTES];
   logic [7:0] upper_ram [memdec_pkg::REG_BYTES];
   logic [7:0] sfr_rdata;
   logic sfr_wr;
   logic [7:0] stack_ptr;

   ////////////////////////////////////////////////////////////////////////
   // register memory address resolution

   logic [7:0] eff_addr;
   logic to_upper_ram;
   logic to_sfr;
   logic lower_wr;
   logic upper_wr;
   logic cyc_end;

   assign cyc_end = state_reg.phase == memdec_pkg::PHASE_LAST;

   always_comb begin
      eff_addr = reg_req.addr;
      unique case (reg_req.mode)
         memdec_pkg::MODE_DIRECT: eff_addr = reg_req.addr;
         memdec_pkg::MODE_INDIRECT: eff_addr = reg_req.index_sel ? state_reg.index1 : state_reg.index0;
         memdec_pkg::MODE_STACK: eff_addr = stack_ptr;
         default: eff_addr = reg_req.addr;
      endcase
   end

   // upper half: direct goes to sfr, indirect/stack to the hidden bank
   assign to_sfr = eff_addr[7] && reg_req.mode == memdec_pkg::MODE_DIRECT;
   assign to_upper_ram = eff_addr[7] && reg_req.mode != memdec_pkg::MODE_DIRECT;
   assign sfr_wr = reg_req.valid && reg_req.write && to_sfr && cyc_end;
   assign upper_wr = reg_req.valid && reg_req.write && to_upper_ram && cyc_end;
   assign lower_wr = reg_req.valid && reg_req.write && !eff_addr[7] && cyc_end;

   // writes commit once per instruction cycle
   always_ff @(posedge clk) begin
      if (lower_wr) begin
         lower_ram[eff_addr[6:0]] <= reg_req.wdata;
      end
      if (upper_wr) begin
         upper_ram[eff_addr[6:0]] <= reg_req.wdata;
      end
   end

   sfr_file u_sfr (
      .clk(clk),
      .sys_rst(sys_rst),
      .wr_en(sfr_wr),
      .addr(eff_addr),
      .wdata(reg_req.wdata),
      .rdata(sfr_rdata),
      .port_e_pins(port_e_pins),
      .port_d_out(port_d_out),
      .stack_ptr(stack_ptr)
   );

   ////////////////////////////////////////////////////////////////////////
   // code/data memory decode

   logic ecs;
   logic internal_hit;
   logic code_req;
   logic int_rd;
   logic ext_fetch;
   logic ext_data;
   logic ext_rd;
   logic ext_wr;

   assign ecs = state_reg.ecs_sync;
   // code space has no write path at all
   assign code_req = mem_req.fetch || mem_req.code_read;
   assign internal_hit = mem_req.addr <= memdec_pkg::INTERNAL_TOP;
   // shared RAM read on fetch OR data read, data read only when ecs high
   assign int_rd = internal_hit && (mem_req.data_read || (code_req && !ecs));
   assign int_ram_rd = int_rd;
   assign int_ram_wr = internal_hit && mem_req.data_write && cyc_end;
   assign int_ram_addr = mem_req.addr[12:0];
   assign int_ram_wdata = mem_req.wdata;

   // all code goes outside from 0000 when ecs high
   assign ext_fetch = code_req && (ecs || !internal_hit);
   assign ext_data = !internal_hit && (mem_req.data_read || mem_req.data_write);
   assign ext_rd = !internal_hit && mem_req.data_read;
   assign ext_wr = !internal_hit && mem_req.data_write;

   ////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      state_next = state_reg;
      state_next.phase = cyc_end ? memdec_pkg::PHASE_RESET : 2'(state_reg.phase + 2'h1);
      state_next.ecs_meta = external_code_select;
      state_next.ecs_sync = state_reg.ecs_meta;
      // hold released as soon as the synchronised select is seen high
      if (state_reg.ecs_sync) begin
         state_next.held = 1'b0;
      end
      // index registers live at the first two lower bytes
      if (lower_wr && eff_addr == 8'h00) begin
         state_next.index0 = reg_req.wdata;
      end
      if (lower_wr && eff_addr == 8'h01) begin
         state_next.index1 = reg_req.wdata;
      end
      if (reg_req.valid && !reg_req.write) begin
         if (to_sfr) begin
            state_next.reg_rdata = sfr_rdata;
         end else if (to_upper_ram) begin
            state_next.reg_rdata = upper_ram[eff_addr[6:0]];
         end else begin
            state_next.reg_rdata = lower_ram[eff_addr[6:0]];
         end
      end
      if (int_rd) begin
         state_next.mem_rdata = int_ram_rdata;
      end else if (ext_fetch || ext_rd) begin
         state_next.mem_rdata = ext_rdata;
      end
      // separate fetch and read pins; internal hits gate all strobes except fetch, cs and oe for code requests while ecs high
      state_next.bus.program_fetch_strobe_n = !ext_fetch;
      state_next.bus.rd_n = !ext_rd;
      state_next.bus.wr_n = !ext_wr;
      state_next.bus.cs_n = !(ext_data || ext_fetch);
      state_next.bus.oe_n = !(ext_rd || ext_fetch);
      state_next.bus.addr = (ext_data || ext_fetch) ? mem_req.addr : memdec_pkg::EXT_CODE_START;
      state_next.bus.wdata = mem_req.wdata;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_reg.phase <= memdec_pkg::PHASE_RESET;
         state_reg.ecs_meta <= 1'b0;
         state_reg.ecs_sync <= 1'b0;
         state_reg.held <= 1'b1;
         state_reg.index0 <= 8'h00;
         state_reg.index1 <= 8'h00;
         state_reg.reg_rdata <= 8'h00;
         state_reg.mem_rdata <= 8'h00;
         state_reg.bus <= '{rd_n: 1'b1, wr_n: 1'b1, cs_n: 1'b1, oe_n: 1'b1,
                            program_fetch_strobe_n: 1'b1, addr: 16'h0000, wdata: 8'h00};
      end else begin
         state_reg <= state_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs

   assign reg_rdata = state_reg.reg_rdata;
   assign mem_rdata = state_reg.mem_rdata;
   assign ext_bus = state_reg.bus;
   assign cycle_strobe = cyc_end;
   // without the select, the core stays held; only the synchronised select high releases it
   assign core_hold = state_reg.held;

endmodule

`default_nettype wire

// ==== src/memdec_pkg.sv ====
package memdec_pkg;

   // register memory map
   localparam logic [7:0] DIRECT_UPPER_BASE = 8'h80;
   localparam int REG_BYTES = 128;
   localparam logic [6:0] REG_RESET = 7'h00;

   // populated special function registers (byte addresses, then reset values)
   localparam logic [7:0] SFR_STACK_PTR = 8'h81;
   localparam logic [7:0] SFR_ACC = 8'hE0;
   localparam logic [7:0] SFR_PORT_D = 8'hB0;
   localparam logic [7:0] SFR_PORT_E = 8'hB1;
   localparam logic [7:0] SFR_DATA_PAGE = 8'h92;
   localparam logic [7:0] SFR_STACK_PTR_RESET = 8'h07;
   localparam logic [7:0] SFR_GENERIC_RESET = 8'h00;

   // code/data memory map
   localparam logic [15:0] INTERNAL_TOP = 16'h1FFF;
   localparam logic [15:0] EXT_CODE_START = 16'h0000;

   // instruction cycle pacing
   localparam int CLK_PERIOD_NS = 10;
   localparam int INSTR_CYCLE_CLOCKS = 4;
   localparam logic [1:0] PHASE_LAST = 2'(INSTR_CYCLE_CLOCKS - 1);
   localparam logic [1:0] PHASE_RESET = 2'h0;

   // register memory access modes
   typedef enum logic [1:0] {
      MODE_DIRECT = 2'b00,
      MODE_INDIRECT = 2'b01,
      MODE_STACK = 2'b10
   } reg_mode_t;

   typedef struct packed {
      logic valid;
      logic write;
      reg_mode_t mode;
      logic index_sel;   // picks index register one when set
      logic [7:0] addr;  // direct address
      logic [7:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic fetch;       // instruction fetch
      logic code_read;   // code memory read instruction
      logic data_read;
      logic data_write;
      logic [15:0] addr;
      logic [7:0] wdata;
   } mem_req_t;

   typedef struct packed {
      logic rd_n;
      logic wr_n;
      logic cs_n;
      logic oe_n;
      logic program_fetch_strobe_n;
      logic [15:0] addr;
      logic [7:0] wdata;
   } ext_bus_t;

endpackage

// ==== src/sfr_file.sv ====
`timescale 1ns/1ns
`default_nettype none

module sfr_file (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // access
   input wire logic wr_en,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata,
   // pins and state
   input wire logic [7:0] port_e_pins,
   output logic [7:0] port_d_out,
   output logic [7:0] stack_ptr
);

   typedef struct packed {
      logic [7:0] sp;
      logic [7:0] acc;
      logic [7:0] port_d;
      logic [7:0] page;
      logic [7:0] pe_meta;
      logic [7:0] pe_sync;
   } sfr_state_t;

   sfr_state_t state_reg;
   sfr_state_t state_next;

   always_comb begin
      state_next = state_reg;
      // port pins are asynchronous, two stages before use
      state_next.pe_meta = port_e_pins;
      state_next.pe_sync = state_reg.pe_meta;
      if (wr_en) begin
         unique case (addr)
            memdec_pkg::SFR_STACK_PTR: state_next.sp = wdata;
            memdec_pkg::SFR_ACC: state_next.acc = wdata;
            memdec_pkg::SFR_PORT_D: state_next.port_d = wdata;
            memdec_pkg::SFR_DATA_PAGE: state_next.page = wdata;
            default: ; // unpopulated writes ignored
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_reg.sp <= memdec_pkg::SFR_STACK_PTR_RESET;
         state_reg.acc <= memdec_pkg::SFR_GENERIC_RESET;
         state_reg.port_d <= memdec_pkg::SFR_GENERIC_RESET;
         state_reg.page <= memdec_pkg::SFR_GENERIC_RESET;
         state_reg.pe_meta <= memdec_pkg::SFR_GENERIC_RESET;
         state_reg.pe_sync <= memdec_pkg::SFR_GENERIC_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

   // sparse map, holes read zero
   always_comb begin
      unique case (addr)
         memdec_pkg::SFR_STACK_PTR: rdata = state_reg.sp;
         memdec_pkg::SFR_ACC: rdata = state_reg.acc;
         memdec_pkg::SFR_PORT_D: rdata = state_reg.port_d;
         memdec_pkg::SFR_PORT_E: rdata = state_reg.pe_sync;
         memdec_pkg::SFR_DATA_PAGE: rdata = state_reg.page;
         default: rdata = 8'h00;
      endcase
   end

   assign port_d_out = state_reg.port_d;
   assign stack_ptr = state_reg.sp;

endmodule

`default_nettype wire

// ==== tb/ext_mem_model.sv ====
`timescale 1ns/1ns
`default_nettype none

module ext_mem_model (
   // clock
   input wire logic clk,
   // request side
   input wire memdec_pkg::mem_req_t mem_req,
   output logic [7:0] ext_rdata
);
   logic [7:0] churn_reg = 8'h00;
   always @(posedge clk) begin
      churn_reg <= churn_reg + 8'h35;
   end
   // idle bus churns so a stale byte never passes for an answer
   // request bits read directly, so the answer follows every read or fetch request, a cycle ahead of the registered strobes
   assign ext_rdata = (mem_req.data_read | mem_req.fetch | mem_req.code_read) ? (mem_req.addr[7:0] ^ 8'h3C)
      : churn_reg;
endmodule

`default_nettype wire

// ==== tb/mem_space_decode_chk.sv ====
`timescale 1ns/1ns
`default_nettype none

module mem_space_decode_chk (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // watched ports
   input wire logic external_code_select,
   input wire memdec_pkg::mem_req_t mem_req,
   input wire logic [7:0] ext_rdata,
   input wire logic [7:0] mem_rdata,
   input wire logic cycle_strobe,
   input wire logic core_hold,
   input wire logic int_ram_rd,
   input wire logic int_ram_wr,
   input wire memdec_pkg::ext_bus_t ext_bus
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   logic code_req, data_only, low_addr;
   assign code_req = mem_req.fetch | mem_req.code_read;
   assign data_only = !code_req && mem_req.data_read;
   assign low_addr = mem_req.addr <= memdec_pkg::INTERNAL_TOP;
   // select passes two flops, so three steady cycles are needed
   sequence sel_lo_s; !external_code_select[*3]; endsequence
   sequence sel_hi_s; external_code_select[*3]; endsequence
   sequence gap_s; !cycle_strobe[*3] ##1 cycle_strobe; endsequence
   ////////////////////////////////////////////////////////////
   int_read_low_a: assert property (sel_lo_s ##0 (code_req || mem_req.data_read) && low_addr |-> int_ram_rd)
      else $error("internal ram not read");
   fetch_goes_ext_a: assert property (sel_hi_s ##0 code_req && !mem_req.data_read |->
      !int_ram_rd ##1 !ext_bus.program_fetch_strobe_n) else $error("fetch not sent out");
   ext_gated_a: assert property (!code_req && (mem_req.data_read || mem_req.data_write) && low_addr |=>
      ext_bus.rd_n && ext_bus.wr_n && ext_bus.cs_n && ext_bus.oe_n) else $error("external strobe leaked");
   split_pins_a: assert property (data_only && !low_addr |=> !ext_bus.rd_n && ext_bus.program_fetch_strobe_n)
      else $error("data read on wrong pin");
   fetch_only_a: assert property (!code_req |=> ext_bus.program_fetch_strobe_n)
      else $error("fetch strobe without fetch");
   cycle_gap_a: assert property ($rose(cycle_strobe) |=> gap_s)
      else $error("instruction cycle not four clocks");
   write_phase_a: assert property (int_ram_wr |-> cycle_strobe)
      else $error("write outside last phase");
   hold_release_a: assert property (sel_hi_s |-> ##[0:2] !core_hold)
      else $error("core held with select high");
   data_answer_a: assert property (data_only && !low_addr |=> mem_rdata == $past(ext_rdata))
      else $error("external read data lost");
endmodule

bind mem_space_decode mem_space_decode_chk chk_u (.clk, .sys_rst, .external_code_select, .mem_req, .ext_rdata,
   .mem_rdata, .cycle_strobe, .core_hold, .int_ram_rd, .int_ram_wr, .ext_bus);

`default_nettype wire

// ==== tb/mem_space_decode_tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none

module mem_space_decode_tb_top;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic external_code_select = 1'b0;
   logic [7:0] port_e_pins = 8'h00;
   memdec_pkg::reg_req_t reg_req = '0;
   memdec_pkg::mem_req_t mem_req = '0;
   logic [7:0] port_d_out, reg_rdata, mem_rdata, int_ram_wdata, int_ram_rdata, ext_rdata, rd, iwd;
   logic [12:0] int_ram_addr;
   logic cycle_strobe, core_hold, int_ram_rd, int_ram_wr, irr, iwr;
   memdec_pkg::ext_bus_t ext_bus;
   int miscompares = 0;
   int n_checks = 0;
   int cycles = 0;
   always #5 clk = ~clk;
   // released ram lines show another pattern than a real read
   assign int_ram_rdata = int_ram_addr[7:0] ^ (int_ram_rd ? 8'hC3 : 8'h5C);
   mem_space_decode dut_u (.clk, .sys_rst, .external_code_select, .port_e_pins, .port_d_out, .reg_req, .reg_rdata,
      .mem_req, .mem_rdata, .cycle_strobe, .core_hold, .int_ram_rd, .int_ram_wr, .int_ram_addr, .int_ram_wdata,
      .int_ram_rdata, .ext_bus, .ext_rdata);
   ext_mem_model ext_u (.clk, .mem_req, .ext_rdata);
   ////////////////////////////////////////////////////////////
   task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chk_bit(input string what, input logic exp, input logic got);
      chk_byte(what, {7'h00, exp}, {7'h00, got});
   endtask
   task automatic conclude();
      if (miscompares == 0 && n_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // requests go out in the last phase so writes commit
   task automatic to_strobe();
      int n;
      n = 0;
      while (cycle_strobe !== 1'b1 && n < 8) begin
         @(posedge clk);
         #1;
         n++;
      end
   endtask
   task automatic reg_op(input logic wr, input memdec_pkg::reg_mode_t md, input logic sel, input logic [7:0] a,
      input logic [7:0] wd);
      to_strobe();
      reg_req = '{1'b1, wr, md, sel, a, wd};
      @(posedge clk);
      #1;
      rd = reg_rdata;
      reg_req = '0;
   endtask
   task automatic mem_op(input logic [3:0] kind, input logic [15:0] a);
      to_strobe();
      mem_req = '{kind[3], kind[2], kind[1], kind[0], a, 8'h77};
      #1;
      irr = int_ram_rd;
      iwr = int_ram_wr;
      iwd = int_ram_wdata;
      @(posedge clk);
      #1;
      mem_req = '0;
   endtask
   ////////////////////////////////////////////////////////////
   task automatic t_direct();
      chk_bit("hold", 1'b1, core_hold);
      reg_op(1'b0, memdec_pkg::MODE_DIRECT, 1'b0, 8'h81, 8'h00);
      chk_byte("stack reset", 8'h07, rd);
      reg_op(1'b1, memdec_pkg::MODE_DIRECT, 1'b0, 8'h22, 8'h5A);
      reg_op(1'b1, memdec_pkg::MODE_DIRECT, 1'b0, 8'hB0, 8'hC7);
      reg_op(1'b1, memdec_pkg::MODE_DIRECT, 1'b0, 8'h85, 8'hFF);
      port_e_pins = 8'h6B;
      reg_op(1'b0, memdec_pkg::MODE_DIRECT, 1'b0, 8'h22, 8'h00);
      chk_byte("gpr 22", 8'h5A, rd);
      chk_byte("port d", 8'hC7, port_d_out);
      reg_op(1'b0, memdec_pkg::MODE_DIRECT, 1'b0, 8'h85, 8'h00);
      chk_byte("hole 85", 8'h00, rd);
      reg_op(1'b0, memdec_pkg::MODE_DIRECT, 1'b0, 8'hB1, 8'h00);
      chk_byte("port e", 8'h6B, rd);
   endtask
   task automatic t_indirect();
      reg_op(1'b1, memdec_pkg::MODE_DIRECT, 1'b0, 8'h00, 8'h90);
      reg_op(1'b1, memdec_pkg::MODE_DIRECT, 1'b0, 8'h01, 8'h22);
      reg_op(1'b1, memdec_pkg::MODE_INDIRECT, 1'b0, 8'h00, 8'hA5);
      reg_op(1'b0, memdec_pkg::MODE_INDIRECT, 1'b0, 8'h00, 8'h00);
      chk_byte("upper 90", 8'hA5, rd);
      reg_op(1'b0, memdec_pkg::MODE_DIRECT, 1'b0, 8'h90, 8'h00);
      chk_byte("sfr 90", 8'h00, rd);
      reg_op(1'b0, memdec_pkg::MODE_INDIRECT, 1'b1, 8'h00, 8'h00);
      chk_byte("low via one", 8'h5A, rd);
      reg_op(1'b1, memdec_pkg::MODE_DIRECT, 1'b0, 8'h81, 8'h98);
      reg_op(1'b1, memdec_pkg::MODE_STACK, 1'b0, 8'h00, 8'h3C);
      reg_op(1'b1, memdec_pkg::MODE_DIRECT, 1'b0, 8'h00, 8'h98);
      reg_op(1'b0, memdec_pkg::MODE_INDIRECT, 1'b0, 8'h00, 8'h00);
      chk_byte("stack byte", 8'h3C, rd);
      reg_op(1'b0, memdec_pkg::MODE_DIRECT, 1'b0, 8'h81, 8'h00);
      chk_byte("stack ptr", 8'h98, rd);
   endtask
   task automatic t_mem_low();
      mem_op(4'b1000, 16'h0100);
      chk_bit("fetch int", 1'b1, irr);
      chk_byte("fetch data", 8'hC3, mem_rdata);
      chk_bit("cs gated", 1'b1, ext_bus.cs_n);
      mem_op(4'b0001, 16'h0005);
      chk_bit("int write", 1'b1, iwr);
      chk_bit("wr gated", 1'b1, ext_bus.wr_n);
      chk_byte("int wdata", 8'h77, iwd);
      mem_op(4'b0010, 16'h2000);
      chk_bit("ext rd", 1'b0, ext_bus.rd_n);
      chk_byte("ext data", 8'h3C, mem_rdata);
      chk_bit("ext oe", 1'b0, ext_bus.oe_n);
      chk_bit("ext cs", 1'b0, ext_bus.cs_n);
      mem_op(4'b1000, 16'h2000);
      chk_bit("ext fetch", 1'b0, ext_bus.program_fetch_strobe_n);
      chk_bit("no rd", 1'b1, ext_bus.rd_n);
      mem_op(4'b0100, 16'h3000);
      chk_bit("code read", 1'b0, ext_bus.program_fetch_strobe_n);
      mem_op(4'b0001, 16'h4000);
      chk_bit("ext wr", 1'b0, ext_bus.wr_n);
      chk_bit("no fetch", 1'b1, ext_bus.program_fetch_strobe_n);
      chk_byte("ext wdata", 8'h77, ext_bus.wdata);
      chk_byte("ext addr hi", 8'h40, ext_bus.addr[15:8]);
   endtask
   task automatic t_sel_high();
      external_code_select = 1'b1;
      repeat (5) @(posedge clk);
      #1;
      chk_bit("run", 1'b0, core_hold);
      mem_op(4'b1000, 16'h0000);
      chk_bit("no int fetch", 1'b0, irr);
      chk_bit("ext fetch 0", 1'b0, ext_bus.program_fetch_strobe_n);
      chk_byte("start addr", 8'h00, ext_bus.addr[7:0]);
      mem_op(4'b1000, 16'h0040);
      chk_bit("no int fetch 40", 1'b0, irr);
      chk_byte("ext addr 40", 8'h40, ext_bus.addr[7:0]);
      chk_byte("ext code 40", 8'h7C, mem_rdata);
      mem_op(4'b0010, 16'h0100);
      chk_bit("int data", 1'b1, irr);
   endtask
   ////////////////////////////////////////////////////////////
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         miscompares++;
         conclude();
      end
   end
   initial begin
      repeat (3) @(posedge clk);
      #1;
      sys_rst = 1'b0;
      t_direct();
      t_indirect();
      t_mem_low();
      t_sel_high();
      conclude();
   end
endmodule

`default_nettype wire
